//--- hdl/bidirectional_pulse_counter.sv
// Signed 16-bit up/down pulse counter with target contact and pulse stretch
// Operation
// - Upcount: contact active while value is at or above the preset.
// - Downcount: contact active while value is at or below zero.
// - Increment past +32767 wraps to -32768.
// - Decrement past -32768 wraps to +32767.
// - Value is net sum of counts since last reset to initial state.
// - Increment input raises value, decrement input lowers it.
// - Repetitive: output drops once the pulse duration has elapsed.
// - Repetitive: recurring condition during pulse restarts full duration.
// - Pulse duration only matters in repetitive cycle mode.
// - Initialization clears value, direct contact off, inverted contact on.
// - Latching keeps the value across a power outage.
// - Value changes only while the count-enable coil is active; the coil gates counting only, reset coil and reloads act regardless.
// - Reset coil loads zero upcounting, preset downcounting.
// - Repetitive: reload on target, zero when up, preset when down.
// - Pulse duration 1 to 32767 in 100 ms units.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps

module bidirectional_pulse_counter #(
    parameter int UNIT_CYCLES = pulse_counter_pkg::UNIT_CYCLES
) (
    input wire logic ref_clk, // System clock, 10 MHz
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic program_init, // Program initialization pulse
    input wire logic power_restore, // Power came back after an outage
    input wire logic increment_input, // Count-up pulse input
    input wire logic decrement_input, // Count-down pulse input
    input wire logic count_enable_coil, // Counting allowed while high
    input wire logic counter_reset_coil, // Reload to initial state
    input wire logic latching_en, // Retain value across outage
    input wire logic lock_en, // Refuse front-panel changes
    input wire logic panel_wr, // Front-panel parameter write strobe
    input wire logic [1:0] panel_sel, // Parameter being written
    input wire logic [15:0] panel_data, // Parameter value
    input wire logic [31:0] sw_addr, // Register address
    input wire logic [31:0] sw_wdata, // Register write data
    input wire logic sw_wr, // Register write strobe
    input wire logic sw_rd, // Register read strobe
    output logic [31:0] sw_rdata, // Register read data, one cycle late
    output logic [15:0] counter_value, // Current signed count
    output logic target_reached_contact, // Direct contact
    output logic target_reached_contact_b, // Inverted contact
    output logic [14:0] panel_preset_view, // Preset shown in menu, zero when locked
    output logic panel_refused, // Front-panel write refused
    output logic irq // Level interrupt
);
    // Register map
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_PRESET = 32'h0000_0004;
    localparam logic [31:0] ADDR_DURATION = 32'h0000_0008;
    localparam logic [31:0] ADDR_VALUE = 32'h0000_000c;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0010;
    localparam logic [31:0] ADDR_MASK = 32'h0000_0014;

    logic upcount_mode_r;
    logic cycle_type_r;
    logic [14:0] preset_r;
    logic [14:0] duration_r;
    logic [15:0] value_r;
    logic [15:0] value_nxt;
    logic [2:0] inc_sync_r;
    logic [2:0] dec_sync_r;
    logic inc_edge;
    logic dec_edge;
    logic target_hit;
    logic pulse_active_r;
    logic [31:0] unit_cnt_r;
    logic [14:0] units_left_r;
    logic [2:0] status_r;
    logic [2:0] mask_r;
    logic [2:0] events;
    logic wr_ctrl;
    logic panel_ok;

    // Three stages: two to synchronise, third only for edge detection
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            inc_sync_r <= 3'h0;
            dec_sync_r <= 3'h0;
        end else begin
            inc_sync_r <= {inc_sync_r[1:0], increment_input};
            dec_sync_r <= {dec_sync_r[1:0], decrement_input};
        end
    end

    assign inc_edge = inc_sync_r[1] & ~inc_sync_r[2];
    assign dec_edge = dec_sync_r[1] & ~dec_sync_r[2];

    // Target condition in signed arithmetic
    always_comb begin
        if (upcount_mode_r) begin
            target_hit = $signed(value_r) >= $signed({1'b0, preset_r});
        end else begin
            target_hit = $signed(value_r) <= $signed(16'h0000);
        end
    end

    // Front-panel parameter changes are refused while locked
    assign panel_ok = panel_wr & ~lock_en;
    assign wr_ctrl = sw_wr & (sw_addr == ADDR_CTRL);

    // Configuration registers, reachable by software and by the front panel
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            upcount_mode_r <= 1'b1;
            cycle_type_r <= pulse_counter_pkg::CYCLE_SINGLE;
            preset_r <= pulse_counter_pkg::PRESET_RESET;
            duration_r <= pulse_counter_pkg::DURATION_RESET;
        end else if (sw_wr) begin
            if (wr_ctrl) begin
                upcount_mode_r <= sw_wdata[0];
                cycle_type_r <= sw_wdata[1];
            end
            if (sw_addr == ADDR_PRESET) begin
                preset_r <= sw_wdata[14:0];
            end
            // Zero is out of range, keep the old duration
            if (sw_addr == ADDR_DURATION && sw_wdata[14:0] >= pulse_counter_pkg::DURATION_MIN) begin
                duration_r <= sw_wdata[14:0];
            end
        end else if (panel_ok) begin
            unique case (panel_sel)
                pulse_counter_pkg::SEL_PRESET: preset_r <= panel_data[14:0];
                pulse_counter_pkg::SEL_DURATION: begin
                    if (panel_data[14:0] >= pulse_counter_pkg::DURATION_MIN) begin
                        duration_r <= panel_data[14:0];
                    end
                end
                pulse_counter_pkg::SEL_MODE: begin
                    upcount_mode_r <= panel_data[0];
                    cycle_type_r <= panel_data[1];
                end
                default: begin
                end
            endcase
        end
    end

    // Next count value; 16-bit add wraps naturally at the signed limits
    always_comb begin
        value_nxt = value_r;
        if (count_enable_coil && (inc_edge ^ dec_edge)) begin
            if (inc_edge) begin
                value_nxt = value_r + 16'h0001;
            end else begin
                value_nxt = value_r - 16'h0001;
            end
        end
    end

    // Counter value: init, outage, reset coil, repetitive reload, counting
    always_ff @(posedge ref_clk) begin
        if (!rst_b || program_init) begin
            value_r <= pulse_counter_pkg::VALUE_RESET;
        end else if (power_restore) begin
            if (!latching_en) begin
                value_r <= pulse_counter_pkg::VALUE_RESET;
            end
        end else if (counter_reset_coil) begin
            value_r <= upcount_mode_r ? pulse_counter_pkg::VALUE_RESET
                                      : {1'b0, preset_r};
        end else if (cycle_type_r == pulse_counter_pkg::CYCLE_REPEAT && target_hit) begin
            value_r <= upcount_mode_r ? pulse_counter_pkg::VALUE_RESET
                                      : {1'b0, preset_r};
        end else begin
            value_r <= value_nxt;
        end
    end

    // Stretch timer: 100 ms tick and a count of remaining units
    always_ff @(posedge ref_clk) begin
        if (!rst_b || program_init || cycle_type_r == pulse_counter_pkg::CYCLE_SINGLE) begin
            pulse_active_r <= 1'b0;
            unit_cnt_r <= 32'h0;
            units_left_r <= 15'h0;
        end else if (target_hit && !counter_reset_coil) begin
            // Condition recurring restarts a full duration
            pulse_active_r <= 1'b1;
            unit_cnt_r <= 32'h0;
            units_left_r <= duration_r;
        end else if (pulse_active_r) begin
            if (unit_cnt_r == 32'(UNIT_CYCLES - 1)) begin
                unit_cnt_r <= 32'h0;
                units_left_r <= units_left_r - 15'h1;
                if (units_left_r == 15'h1) begin
                    pulse_active_r <= 1'b0;
                end
            end else begin
                unit_cnt_r <= unit_cnt_r + 32'h1;
            end
        end
    end

    // Contacts and visible value, all registered
    always_ff @(posedge ref_clk) begin
        if (!rst_b || program_init) begin
            target_reached_contact <= 1'b0;
            target_reached_contact_b <= 1'b1;
            counter_value <= pulse_counter_pkg::VALUE_RESET;
            panel_preset_view <= 15'h0;
            panel_refused <= 1'b0;
        end else begin
            if (cycle_type_r == pulse_counter_pkg::CYCLE_REPEAT) begin
                target_reached_contact <= pulse_active_r;
                target_reached_contact_b <= ~pulse_active_r;
            end else begin
                target_reached_contact <= target_hit;
                target_reached_contact_b <= ~target_hit;
            end
            counter_value <= value_r;
            panel_preset_view <= lock_en ? 15'h0 : preset_r;
            panel_refused <= panel_wr & lock_en;
        end
    end

    // Events: target reached, wrap, refused panel write
    assign events[0] = target_hit & ~(cycle_type_r == pulse_counter_pkg::CYCLE_REPEAT
                       ? 1'b0 : target_reached_contact);
    assign events[1] = (value_nxt == pulse_counter_pkg::VALUE_MIN && value_r == pulse_counter_pkg::VALUE_MAX)
                     | (value_nxt == pulse_counter_pkg::VALUE_MAX && value_r == pulse_counter_pkg::VALUE_MIN);
    assign events[2] = panel_wr & lock_en;

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            status_r <= 3'h0;
        end else if (sw_wr && sw_addr == ADDR_STATUS) begin
            status_r <= (status_r & ~sw_wdata[2:0]) | events;
        end else begin
            status_r <= status_r | events;
        end
    end

    // Interrupt mask
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            mask_r <= 3'h0;
        end else if (sw_wr && sw_addr == ADDR_MASK) begin
            mask_r <= sw_wdata[2:0];
        end
    end

    // Interrupt level from a flip-flop, one cycle behind status
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_r & mask_r);
        end
    end

    // Read data one cycle after the strobe, zero otherwise and when unmapped
    always_ff @(posedge ref_clk) begin
        if (!rst_b || !sw_rd) begin
            sw_rdata <= 32'h0;
        end else begin
            unique case (sw_addr)
                ADDR_CTRL: sw_rdata <= {30'h0, cycle_type_r, upcount_mode_r};
                ADDR_PRESET: sw_rdata <= {17'h0, preset_r};
                ADDR_DURATION: sw_rdata <= {17'h0, duration_r};
                ADDR_VALUE: sw_rdata <= {16'h0, value_r};
                ADDR_STATUS: sw_rdata <= {28'h0, pulse_active_r, status_r};
                ADDR_MASK: sw_rdata <= {29'h0, mask_r};
                default: sw_rdata <= 32'h0;
            endcase
        end
    end
endmodule

//--- hdl/pulse_counter_pkg.sv
// Constants shared by the bidirectional pulse counter
package pulse_counter_pkg;
    localparam int VALUE_W = 16;
    localparam logic [15:0] VALUE_MAX = 16'h7fff;
    localparam logic [15:0] VALUE_MIN = 16'h8000;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam logic [14:0] PRESET_RESET = 15'h0000;
    localparam logic [14:0] DURATION_RESET = 15'h0001;
    localparam logic [14:0] DURATION_MIN = 15'h0001;
    // Pulse duration unit and clock rate
    localparam int UNIT_MS = 100;
    localparam int CLK_HZ = 10000000;
    localparam int UNIT_CYCLES = (CLK_HZ / 1000) * UNIT_MS;
    // Cycle type and front-panel write select
    localparam logic CYCLE_SINGLE = 1'b0;
    localparam logic CYCLE_REPEAT = 1'b1;
    localparam logic [1:0] SEL_PRESET = 2'h0;
    localparam logic [1:0] SEL_DURATION = 2'h1;
    localparam logic [1:0] SEL_MODE = 2'h2;
endpackage

//--- test/bidirectional_pulse_counter_tb.sv
// Self-checking testbench for the bidirectional pulse counter
`timescale 1ns/1ps
module bidirectional_pulse_counter_tb;
    logic ref_clk, rst_b, program_init, power_restore, count_enable_coil, counter_reset_coil;
    logic latching_en, lock_en, panel_wr, sw_wr, sw_rd, increment_input, decrement_input;
    logic target_reached_contact, target_reached_contact_b, panel_refused, irq;
    logic [1:0] panel_sel;
    logic [15:0] panel_data, counter_value;
    logic [14:0] panel_preset_view;
    logic [31:0] sw_addr, sw_wdata, sw_rdata;
    int n_mismatch = 0;
    int compares = 0;
    // Short time unit keeps the repetitive pulse at 20 cycles
    bidirectional_pulse_counter #(.UNIT_CYCLES(10)) bidirectional_pulse_counter_i (.ref_clk,
        .rst_b, .program_init, .power_restore, .increment_input, .decrement_input,
        .count_enable_coil, .counter_reset_coil, .latching_en, .lock_en, .panel_wr, .panel_sel,
        .panel_data, .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata, .counter_value,
        .target_reached_contact, .target_reached_contact_b, .panel_preset_view, .panel_refused,
        .irq);
    pulse_source pulse_source_i (.ref_clk, .increment_input, .decrement_input);
    initial begin
        ref_clk = 1'h0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string nm);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic stop_test;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'h1;
        @(posedge ref_clk);
        sw_wr <= 1'h0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
        input string nm);
        @(posedge ref_clk);
        sw_addr <= a;
        sw_rd <= 1'h1;
        @(posedge ref_clk);
        sw_rd <= 1'h0;
        #1 chk(e, sw_rdata & m, nm);
    endtask
    // Pulses through the partner, then checks count and contact once settled
    task automatic cnt(input logic u, input logic d, input int n, input logic [15:0] v,
        input logic k);
        pulse_source_i.pulse(u, d, n);
        cyc(2);
        chk(v, counter_value, "value");
        chk(k, target_reached_contact, "contact");
    endtask
    task automatic coil;
        @(posedge ref_clk);
        counter_reset_coil <= 1'h1;
        @(posedge ref_clk);
        counter_reset_coil <= 1'h0;
        cyc(3);
    endtask
    task automatic t_init;
        @(posedge ref_clk);
        program_init <= 1'h1;
        @(posedge ref_clk);
        program_init <= 1'h0;
        #1 chk(0, target_reached_contact, "contact");
        chk(1, target_reached_contact_b, "contact_b");
        chk(0, counter_value, "value");
    endtask
    task automatic t_up;
        wr(32'h4, 32'h3);
        wr(32'h0, 32'h1);
        coil();
        cnt(1, 0, 2, 16'h0002, 0);
        cnt(1, 0, 1, 16'h0003, 1);
        cnt(0, 1, 1, 16'h0002, 0);
        count_enable_coil <= 1'h0;
        cnt(1, 0, 1, 16'h0002, 0);
        count_enable_coil <= 1'h1;
    endtask
    task automatic t_down;
        wr(32'h0, 32'h0);
        wr(32'h4, 32'h2);
        coil();
        chk(16'h0002, counter_value, "reload");
        cnt(0, 1, 2, 16'h0000, 1);
        cnt(0, 1, 1, 16'hffff, 1);
        wr(32'h4, 32'h7fff);
        coil();
        cnt(1, 0, 1, 16'h8000, 1);
        cnt(0, 1, 1, 16'h7fff, 0);
        cnt(1, 1, 1, 16'h7fff, 0);
        rd(32'hc, 32'hffff, 32'h7fff, "value reg");
        rd(32'h40, 32'hffff_ffff, 32'h0, "unmapped");
    endtask
    task automatic t_rep;
        wr(32'h8, 32'h2);
        wr(32'h4, 32'h2);
        wr(32'h0, 32'h3);
        coil();
        wr(32'h14, 32'h0);
        wr(32'h10, 32'hf);
        cnt(1, 0, 2, 16'h0000, 1);
        chk(0, irq, "masked irq");
        cnt(1, 0, 2, 16'h0000, 1);
        cyc(10);
        chk(1, target_reached_contact, "stretched");
        cyc(15);
        chk(0, target_reached_contact, "expired");
        rd(32'h10, 32'h1, 32'h1, "status");
        wr(32'h14, 32'h1);
        cyc(2);
        chk(1, irq, "irq");
        wr(32'h10, 32'h1);
        cyc(2);
        chk(0, irq, "irq cleared");
    endtask
    task automatic t_lock;
        lock_en <= 1'h1;
        @(posedge ref_clk);
        panel_wr <= 1'h1;
        @(posedge ref_clk);
        panel_wr <= 1'h0;
        #1 chk(1, panel_refused, "refused");
        chk(0, panel_preset_view, "view locked");
        rd(32'h4, 32'h7fff, 32'h2, "preset kept");
        lock_en <= 1'h0;
        cyc(2);
        chk(2, panel_preset_view, "view");
    endtask
    task automatic t_power;
        cnt(1, 0, 1, 16'h0001, 0);
        latching_en <= 1'h1;
        @(posedge ref_clk);
        power_restore <= 1'h1;
        @(posedge ref_clk);
        power_restore <= 1'h0;
        cyc(3);
        chk(1, counter_value, "latched");
        latching_en <= 1'h0;
        power_restore <= 1'h1;
        @(posedge ref_clk);
        power_restore <= 1'h0;
        cyc(3);
        chk(0, counter_value, "cleared");
    endtask
    initial begin
        cyc(5000);
        n_mismatch++;
        stop_test();
    end
    initial begin
        {rst_b, program_init, power_restore, counter_reset_coil, latching_en} = '0;
        {lock_en, panel_wr, sw_wr, sw_rd, panel_sel, sw_addr, sw_wdata} = '0;
        panel_data = 16'h0005;
        count_enable_coil = 1'h1;
        cyc(6);
        rst_b <= 1'h1;
        t_init();
        t_up();
        t_down();
        t_rep();
        t_lock();
        t_power();
        stop_test();
    end
endmodule

//--- test/pulse_counter_monitor.sv
// Port-level assertion checker for the bidirectional pulse counter
`timescale 1ns/1ps
module pulse_counter_monitor #(
    parameter int UNIT_CYCLES = 10
) (
    input wire logic ref_clk, // Clock
    input wire logic rst_b, // Reset, active low
    input wire logic program_init, // Initialization
    input wire logic power_restore, // Outage over
    input wire logic count_enable_coil, // Count enable
    input wire logic counter_reset_coil, // Reload
    input wire logic latching_en, // Retain value
    input wire logic lock_en, // Panel lock
    input wire logic panel_wr, // Panel write
    input wire logic sw_wr, // Register write
    input wire logic sw_rd, // Register read
    input wire logic [31:0] sw_rdata, // Read data
    input wire logic [15:0] counter_value, // Count
    input wire logic target_reached_contact, // Direct contact
    input wire logic target_reached_contact_b, // Inverted contact
    input wire logic [14:0] panel_preset_view, // Menu preset
    input wire logic panel_refused // Refused write
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Five cycles in which nothing may move the count; covers the input pipeline
    sequence quiet_s;
        (!count_enable_coil && !program_init && !power_restore && !counter_reset_coil
            && !sw_wr)[*5];
    endsequence
    // Clearing source alone; the assertion adds the two pipeline stages with ##2
    sequence clear_s;
        program_init || (power_restore && !latching_en);
    endsequence
    contact_pair_a: assert property (target_reached_contact_b == !target_reached_contact)
        else $error("contacts not complementary");
    init_value_a: assert property (clear_s |-> ##2 counter_value == 16'h0000)
        else $error("count not cleared");
    init_contact_a: assert property (program_init |=> !target_reached_contact)
        else $error("contact active after init");
    hold_off_a: assert property (quiet_s |=> $stable(counter_value))
        else $error("count moved while disabled");
    lock_view_a: assert property ($past(lock_en) |-> panel_preset_view == 15'h0000)
        else $error("preset shown while locked");
    refuse_lock_a: assert property (panel_wr && lock_en |=> panel_refused)
        else $error("locked panel write not refused");
    refuse_only_a: assert property (!panel_wr |=> !panel_refused)
        else $error("refusal without panel write");
    rdata_idle_a: assert property (!sw_rd |=> sw_rdata == 32'h0000_0000)
        else $error("read data outside read slot");
endmodule

bind bidirectional_pulse_counter pulse_counter_monitor #(.UNIT_CYCLES(UNIT_CYCLES)) mon_i (.*);

//--- test/pulse_source.sv
// Far-side pulse source feeding the increment and decrement inputs
`timescale 1ns/1ps
module pulse_source (
    input wire logic ref_clk, // System clock
    output logic increment_input, // Up pulses
    output logic decrement_input // Down pulses
);
    initial begin
        increment_input = 1'h0;
        decrement_input = 1'h0;
    end
    // Three cycles high, four low between pulses: slow enough for the two-stage synchroniser
    task automatic pulse(input logic up, input logic dn, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            increment_input <= up;
            decrement_input <= dn;
            repeat (3) @(posedge ref_clk);
            increment_input <= 1'h0;
            decrement_input <= 1'h0;
            repeat (3) @(posedge ref_clk);
        end
    endtask
endmodule
